// [afud_pkg.sv]
// Shared constants and types for the alpha field 16-bit character decoder
package afud_pkg;

	// ------------------------------------------------------------
	// Lead byte codes and padding
	// ------------------------------------------------------------
	localparam logic [7:0] LEAD_UCS = 8'h80;
	localparam logic [7:0] LEAD_HALF = 8'h81;
	localparam logic [7:0] LEAD_FULL = 8'h82;
	localparam logic [7:0] PAD_BYTE = 8'hFF;
	localparam logic [15:0] PAD_PAIR = 16'hFFFF;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int OFS_BITS = 7;
	localparam logic [6:0] BASE_LOW_ZERO = 7'h00;
	localparam logic [15:0] RST_CODE = 16'h0000;
	localparam logic [15:0] RST_BASE = 16'h0000;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;

	// Coding selected by the lead byte
	typedef enum logic [1:0] {
		FORM_PLAIN = 2'b00,
		FORM_UCS = 2'b01,
		FORM_HALF = 2'b10,
		FORM_FULL = 2'b11
	} afud_form_t;

	// Decoder states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_COUNT = 4'b0001,
		ST_BASE_HI = 4'b0010,
		ST_BASE_LO = 4'b0011,
		ST_CHARS = 4'b0100,
		ST_UCS_HI = 4'b0101,
		ST_UCS_LO = 4'b0110,
		ST_PLAIN = 4'b0111,
		ST_SKIP = 4'b1000
	} afud_state_t;

endpackage

// [afud_char_map.sv]
// Maps one counted-form byte onto a default-alphabet or offset character code
`timescale 1ns/1ps
module afud_char_map
	import afud_pkg::*;
(
	input wire logic [7:0] code_byte,
	input wire logic [15:0] base,
	output logic [15:0] code,
	output logic is_gsm
);

	// ------------------------------------------------------------
	// Top bit picks alphabet character or offset from base
	// ------------------------------------------------------------
	always_comb begin
		is_gsm = ~code_byte[7];
		if (code_byte[7]) begin
			code = base + {9'h000, code_byte[OFS_BITS-1:0]};
		end else begin
			code = {9'h000, code_byte[OFS_BITS-1:0]};
		end
	end

endmodule // afud_char_map

// [afud_char_count.sv]
// Down counter of characters still owed by a counted form
`timescale 1ns/1ps
module afud_char_count
	import afud_pkg::*;
#(
	parameter int CW = 8
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [CW-1:0] load_val,
	input wire logic dec,
	output logic [CW-1:0] count,
	output logic is_one,
	output logic is_zero
);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	// Load wins over decrement; never wraps below zero
	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = load_val;
		end else if (dec && cnt_q != '0) begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= CW'(RST_COUNT);
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign count = cnt_q;
	assign is_one = (cnt_q == CW'(1));
	assign is_zero = (cnt_q == '0);

endmodule // afud_char_count

// [afud_decoder.sv]
// Alpha field decoder: record bytes in, 16-bit character codes out
`timescale 1ns/1ps
module afud_decoder
	import afud_pkg::*;
#(
	parameter int CW = 8
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic in_valid,
	input wire logic in_start,
	input wire logic in_last,
	input wire logic [7:0] in_byte,
	output logic out_valid,
	output logic [15:0] out_code,
	output logic out_gsm,
	output logic out_done,
	output logic out_short,
	output logic [1:0] out_form
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	afud_state_t st_q, st_d;
	afud_form_t form_q, form_d;
	logic [7:0] hi_q, hi_d;
	logic [15:0] base_q, base_d;
	logic val_q, val_d;
	logic [15:0] code_q, code_d;
	logic gsm_q, gsm_d;
	logic done_q, done_d;
	logic short_q, short_d;
	logic cnt_load, cnt_dec, cnt_one, cnt_zero;
	logic [CW-1:0] cnt;
	logic [15:0] map_code;
	logic map_gsm;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	afud_char_count #(.CW(CW)) u_count (
		.clk(clk),
		.reset_n(reset_n),
		.load(cnt_load),
		.load_val(in_byte[CW-1:0]),
		.dec(cnt_dec),
		.count(cnt),
		.is_one(cnt_one),
		.is_zero(cnt_zero)
	);

	afud_char_map u_map (
		.code_byte(in_byte),
		.base(base_q),
		.code(map_code),
		.is_gsm(map_gsm)
	);

	// ------------------------------------------------------------
	// Next state and output values
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		// form held unless a start byte arrives
		form_d = form_q;
		hi_d = hi_q;
		base_d = base_q;
		val_d = 1'b0;
		code_d = code_q;
		gsm_d = gsm_q;
		done_d = 1'b0;
		short_d = 1'b0;
		cnt_load = 1'b0;
		cnt_dec = 1'b0;
		if (in_valid) begin
			if (in_start) begin
				// A start byte always restarts, so a cut record cannot leak its form
				case (in_byte)
					LEAD_UCS: begin
						form_d = FORM_UCS;
						st_d = ST_UCS_HI;
					end
					LEAD_HALF: begin
						form_d = FORM_HALF;
						st_d = ST_COUNT;
					end
					LEAD_FULL: begin
						form_d = FORM_FULL;
						st_d = ST_COUNT;
					end
					default: begin
						form_d = FORM_PLAIN;
						st_d = ST_PLAIN;
						if (in_byte == PAD_BYTE) begin
							st_d = ST_SKIP;
						end else begin
							val_d = 1'b1;
							gsm_d = 1'b1;
							code_d = {8'h00, in_byte};
						end
					end
				endcase
			end else begin
				case (st_q)
					ST_COUNT: begin
						cnt_load = 1'b1;
						st_d = ST_BASE_HI;
					end
					ST_BASE_HI: begin
						if (form_q == FORM_HALF) begin
							base_d = {1'b0, in_byte, BASE_LOW_ZERO};
							st_d = cnt_zero ? ST_SKIP : ST_CHARS;
						end else begin
							hi_d = in_byte;
							st_d = ST_BASE_LO;
						end
					end
					ST_BASE_LO: begin
						base_d = {hi_q, in_byte};
						st_d = cnt_zero ? ST_SKIP : ST_CHARS;
					end
					ST_CHARS: begin
						val_d = 1'b1;
						code_d = map_code;
						gsm_d = map_gsm;
						cnt_dec = 1'b1;
						if (cnt_one) begin
							st_d = ST_SKIP;
						end
					end
					ST_UCS_HI: begin
						hi_d = in_byte;
						st_d = ST_UCS_LO;
					end
					ST_UCS_LO: begin
						if ({hi_q, in_byte} == PAD_PAIR) begin
							st_d = ST_SKIP;
						end else begin
							val_d = 1'b1;
							gsm_d = 1'b0;
							code_d = {hi_q, in_byte};
							st_d = ST_UCS_HI;
						end
					end
					ST_PLAIN: begin
						if (in_byte == PAD_BYTE) begin
							st_d = ST_SKIP;
						end else begin
							val_d = 1'b1;
							gsm_d = 1'b1;
							code_d = {8'h00, in_byte};
						end
					end
					default: begin
					end
				endcase
				// Record too short for its count: flagged, never stalls
				case (st_q)
					ST_COUNT: short_d = in_last && (in_byte != 8'h00);
					ST_BASE_HI, ST_BASE_LO: short_d = in_last && !cnt_zero;
					ST_CHARS: short_d = in_last && !cnt_one;
					default: short_d = 1'b0;
				endcase
			end
			// a lone final byte in the upper slot is dropped here
			if (in_last) begin
				st_d = ST_IDLE;
				done_d = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= ST_IDLE;
			form_q <= FORM_PLAIN;
			hi_q <= RST_BYTE;
			base_q <= RST_BASE;
			val_q <= 1'b0;
			code_q <= RST_CODE;
			gsm_q <= 1'b0;
			done_q <= 1'b0;
			short_q <= 1'b0;
		end else begin
			st_q <= st_d;
			form_q <= form_d;
			hi_q <= hi_d;
			base_q <= base_d;
			val_q <= val_d;
			code_q <= code_d;
			gsm_q <= gsm_d;
			done_q <= done_d;
			short_q <= short_d;
		end
	end

	assign out_valid = val_q;
	assign out_code = code_q;
	assign out_gsm = gsm_q;
	assign out_done = done_q;
	assign out_short = short_q;
	assign out_form = form_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	logic mid;
	assign mid = in_valid && !in_start;

	sequence s_last_char;
		st_q == ST_CHARS && mid && cnt_one && !in_last;
	endsequence

	sequence s_pair_in;
		st_q == ST_UCS_HI && mid && !in_last ##1 st_q == ST_UCS_LO && mid;
	endsequence

	chk_ucs_pair: assert property (
		s_pair_in ##0 ({hi_q, in_byte} != PAD_PAIR) |=> out_valid && !out_gsm)
		else $error("two-byte pair gave no character");

	chk_pair_order: assert property (
		s_pair_in ##0 ({hi_q, in_byte} != PAD_PAIR) |=> out_code == {$past(hi_q), $past(in_byte)})
		else $error("two-byte code halves swapped");

	chk_pad_drop: assert property (
		st_q == ST_UCS_LO && mid && {hi_q, in_byte} == PAD_PAIR |=> !out_valid ##0 (st_q == ST_SKIP || st_q == ST_IDLE))
		else $error("padding pair produced output");

	chk_count_load: assert property (
		st_q == ST_COUNT && mid |=> cnt == $past(in_byte[CW-1:0]))
		else $error("character count not captured");

	chk_base_half: assert property (
		st_q == ST_BASE_HI && form_q == FORM_HALF && mid |=> base_q == {1'b0, $past(in_byte), BASE_LOW_ZERO})
		else $error("half-page base wrong");

	chk_gsm_char: assert property (
		st_q == ST_CHARS && mid && !in_byte[7] |=> out_valid && out_gsm && out_code == {9'h000, $past(in_byte[6:0])})
		else $error("alphabet character wrong");

	chk_base_full: assert property (
		st_q == ST_BASE_LO && mid |=> base_q == {$past(hi_q), $past(in_byte)})
		else $error("full base pointer wrong");

	chk_offset_char: assert property (
		st_q == ST_CHARS && mid && in_byte[7] |=> out_valid && !out_gsm && out_code == $past(base_q) + {9'h000, $past(in_byte[6:0])})
		else $error("offset character wrong");

	// 0xFF inside count is a character
	chk_ff_counted: assert property (
		st_q == ST_CHARS && mid && in_byte == PAD_BYTE |=> out_valid && out_code == $past(base_q) + 16'h007F)
		else $error("counted 0xFF treated as padding");

	chk_count_end: assert property (
		s_last_char |=> st_q == ST_SKIP ##1 (!out_valid || $past(in_valid && in_start)))
		else $error("string ran past its count");

	chk_one_form: assert property (
		!(in_valid && in_start) |=> $stable(form_q))
		else $error("coding changed inside record");

	chk_plain_lead: assert property (
		in_valid && in_start && in_byte[7:2] != 6'h20 && in_byte != PAD_BYTE |=> out_valid && out_gsm && out_form == FORM_PLAIN)
		else $error("unknown lead not plain");

endmodule // afud_decoder

// [afud_rec_src.sv]
// Record byte source model standing in for the card file reader
`timescale 1ns/1ps
module afud_rec_src (
	input wire logic clk,
	output logic in_valid,
	output logic in_start,
	output logic in_last,
	output logic [7:0] in_byte
);
	// ------------------------------------------------------------
	// Idle levels
	// ------------------------------------------------------------
	initial begin
		in_valid = 1'b0;
		in_start = 1'b0;
		in_last = 1'b0;
		in_byte = 8'h00;
	end

	// ------------------------------------------------------------
	// Record streaming
	// ------------------------------------------------------------
	// one coding per record
	// Gap cycles show the inverted byte so a stale value never looks valid
	task automatic send(input logic [7:0] b[$], input int gap, input logic last);
		foreach (b[i]) begin
			@(posedge clk);
			in_valid <= 1'b1;
			in_start <= (i == 0);
			in_last <= last && (i == b.size() - 1);
			in_byte <= b[i];
			repeat (gap) begin
				@(posedge clk);
				in_valid <= 1'b0;
				in_start <= 1'b0;
				in_last <= 1'b0;
				in_byte <= ~b[i];
			end
		end
		@(posedge clk);
		in_valid <= 1'b0;
		in_start <= 1'b0;
		in_last <= 1'b0;
		in_byte <= ~in_byte;
	endtask
endmodule // afud_rec_src

// [tb.sv]
// Self-checking testbench for the alpha field decoder
`timescale 1ns/1ps
module tb
	import afud_pkg::*;
;
	logic clk;
	logic reset_n;
	logic in_valid, in_start, in_last, out_valid, out_gsm, out_done, out_short;
	logic [7:0] in_byte;
	logic [15:0] out_code;
	logic [1:0] out_form;
	logic [15:0] got[$];
	logic gsm_q[$];
	logic last_short;
	int dones;
	int miscompares = 0;
	int checks = 0;

	// ------------------------------------------------------------
	// Clock, parts and monitor
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	afud_rec_src src (.clk(clk), .in_valid(in_valid), .in_start(in_start), .in_last(in_last), .in_byte(in_byte));

	afud_decoder uut (.clk(clk), .reset_n(reset_n), .in_valid(in_valid), .in_start(in_start),
		.in_last(in_last), .in_byte(in_byte), .out_valid(out_valid), .out_code(out_code),
		.out_gsm(out_gsm), .out_done(out_done), .out_short(out_short), .out_form(out_form));

	// Pulses stand one cycle, so they are gathered at every edge
	always @(posedge clk) begin
		if (out_valid === 1'b1) begin
			got.push_back(out_code);
			gsm_q.push_back(out_gsm);
		end
		if (out_done === 1'b1) begin
			dones++;
			last_short = out_short;
		end
	end

	// ------------------------------------------------------------
	// Compare and run helpers
	// ------------------------------------------------------------
	task automatic cmp_code(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cmp_bit(input logic g, input logic e);
		cmp_code({15'h0000, g}, {15'h0000, e});
	endtask

	// Streams one record, then judges codes, kinds, form, end and shortfall
	task automatic run(input logic [7:0] b[$], input int gap, input logic [15:0] e[$], input logic [7:0] gm,
		input afud_form_t f, input logic s);
		got.delete();
		gsm_q.delete();
		dones = 0;
		src.send(b, gap, 1'b1);
		repeat (3) @(posedge clk);
		cmp_code(16'(got.size()), 16'(e.size()));
		foreach (e[i]) begin
			cmp_code(got[i], e[i]);
			cmp_bit(gsm_q[i], gm[i]);
		end
		cmp_code({14'h0000, out_form}, {14'h0000, f});
		cmp_code(16'(dones), 16'h0001);
		cmp_bit(last_short, s);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_ucs();
		run('{8'h80, 8'h09, 8'h95, 8'h00, 8'h41, 8'hFF, 8'hFF, 8'hFF}, 0, '{16'h0995, 16'h0041}, 8'h00,
			FORM_UCS, 1'b0);
		run('{8'h80, 8'h12, 8'h34, 8'hFF}, 1, '{16'h1234}, 8'h00, FORM_UCS, 1'b0);
	endtask

	task automatic t_half();
		run('{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h20, 8'hFF, 8'hFF}, 2,
			'{16'h0053, 16'h0995, 16'h09A6, 16'h0020, 16'h09FF}, 8'h09, FORM_HALF, 1'b0);
	endtask

	// An unfinished two-byte record is cut off by the next start byte
	task automatic t_abort_full();
		src.send('{8'h80, 8'h12}, 0, 1'b0);
		run('{8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31}, 0,
			'{16'h002D, 16'h0532, 16'h0583, 16'h002D, 16'h0031}, 8'h19, FORM_FULL, 1'b0);
	endtask

	task automatic t_short();
		run('{8'h81, 8'h04, 8'h13, 8'h53, 8'h95}, 0, '{16'h0053, 16'h0995}, 8'h01, FORM_HALF, 1'b1);
	endtask

	task automatic t_plain();
		run('{8'h41, 8'h42, 8'hFF, 8'h43}, 0, '{16'h0041, 16'h0042}, 8'h03, FORM_PLAIN, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Verdict, watchdog and main sequence
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Whole run is under a hundred cycles; the limit of 3000 leaves wide margin
	initial begin
		#(20 * 3000);
		miscompares++;
		finish_test();
	end

	initial begin
		reset_n = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		cmp_code({11'h000, out_valid, out_done, out_short, out_form}, 16'h0000);
		@(posedge clk);
		reset_n <= 1'b1;
		t_ucs();
		t_half();
		t_abort_full();
		t_short();
		t_plain();
		finish_test();
	end
endmodule // tb
